// ==== design/cai_pkg.sv ====
// Package of the converter alarm interlock: APB map, field layout, reset values.
// Assumes a 32-bit APB slave on pclk; all registers are one aligned word.
package cai_pkg;

	localparam logic [7:0] CAI_OFS_CTRL = 8'h00;
	localparam logic [7:0] CAI_OFS_STATUS = 8'h04;
	localparam logic [7:0] CAI_OFS_CAUSE = 8'h08;

	// Control register fields
	localparam int CAI_CTRL_SW_LSB = 0;
	localparam int CAI_CTRL_SW_W = 4;
	localparam int CAI_CTRL_MULTI_BIT = 4;
	localparam int CAI_CTRL_FCLR_BIT = 5;
	localparam logic [3:0] CAI_SW_NO_CONTACTOR = 4'h1;
	localparam logic [3:0] CAI_CTRL_SW_RST = 4'h0;

	// Status register fields
	localparam int CAI_ST_CONV_ALARM = 0;
	localparam int CAI_ST_CONTACTOR = 1;
	localparam int CAI_ST_DRV_REPORT = 2;
	localparam int CAI_ST_FAULT_FLAG = 3;
	localparam int CAI_ST_NOT_READY = 4;
	localparam int CAI_ST_STATE_LSB = 5;

	// Fault-clear minimum hold time
	localparam int CAI_FCLR_MIN_MS = 100;
	localparam int CAI_CLK_MHZ = 250;
	localparam int CAI_FCLR_CYCLES = CAI_FCLR_MIN_MS * 1000 * CAI_CLK_MHZ;

	typedef enum logic [1:0] {
		CAI_IDLE = 2'b00,
		CAI_RUN = 2'b01,
		CAI_TRIP = 2'b11
	} cai_state_e;

	typedef struct packed {
		logic drive_start;
		logic servo_on;
		logic drive_alarm;
		logic conv_fault;
	} cai_in_s;

	typedef struct packed {
		logic alarm_contact_nc;
		logic alarm_contact_no;
		logic contactor_drive;
		logic drive_alarm_report;
		logic fault_flag_output;
		logic not_ready;
	} cai_out_s;

endpackage : cai_pkg

// ==== design/cai_hold_filter.sv ====
// Hold filter: pulses once when an input falls after a minimum high time.
// Assumes the input is synchronous to clk.
`timescale 1ns/1ps
module cai_hold_filter #(
	parameter int HOLD_CYCLES = 1000
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic level, // Level to qualify
	output logic done // One-cycle pulse on a qualified release
);
	localparam int CW = $clog2(HOLD_CYCLES + 1);

	initial begin
		if (HOLD_CYCLES < 1) begin
			$error("HOLD_CYCLES must be at least 1");
		end
	end

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic done;
	} cai_hold_s;

	cai_hold_s r;
	cai_hold_s next_r;

	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		if (level) begin
			if (r.cnt != CW'(HOLD_CYCLES)) begin
				next_r.cnt = r.cnt + CW'(1);
			end
		end else begin
			next_r.done = (r.cnt == CW'(HOLD_CYCLES));
			next_r.cnt = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign done = r.done;

endmodule : cai_hold_filter

// ==== design/cai_interlock.sv ====
// Converter alarm and contactor interlock sequencer with an APB register slave.
// Assumes all pins are synchronous to pclk; presetn models control power cycling.
`timescale 1ns/1ps
// Summary of operation
// - Alarm contact is changeover: fault opens NC pair and closes NO pair.
// - Alarm contact asserts whenever protection trips and power delivery stops.
// - Contactor output closes when drive unit issues a start command.
// - With contactor enabled, converter alarm opens contactor and stops drive.
// - Latched alarm clears only on power cycle or servo-on, cause removed.
// - Alarm during servo-off is not reported to the drive unit.
// - Alarm during servo-on is propagated; drive alarms and goes servo-off.
// - Main power applied only after start and with no alarm anywhere.
// - With contactor disabled, alarm forces servo-off but keeps main power.
// - Multi-axis alarm clears by power cycle or linked axis servo-on request.
// - Fault flag output is low whenever an alarm is present.
module cai_interlock
	import cai_pkg::*;
#(
	parameter int FCLR_CYCLES = CAI_FCLR_CYCLES
) (
	input wire logic pclk, // APB clock, 250 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire cai_in_s link_in, // Drive unit and protection inputs
	input wire logic fault_clear_input, // Fault-clear pin, active high
	output cai_out_s link_out // Contact, contactor and flag outputs
);

	initial begin
		if (FCLR_CYCLES < 1) begin
			$error("FCLR_CYCLES must be at least 1");
		end
	end

	typedef struct packed {
		cai_state_e state;
		logic [CAI_CTRL_SW_W-1:0] setting_sw;
		logic multi_axis;
		logic fclr_sw;
		logic conv_alarm;
		logic servo_on_d;
		logic not_ready;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		cai_out_s out;
	} cai_state_s;

	cai_state_s r;
	cai_state_s next_r;
	logic fclr_done;
	logic contactor_en;
	logic clear_req;
	logic any_alarm;
	logic [31:0] status_word;

	cai_hold_filter #(
		.HOLD_CYCLES(FCLR_CYCLES)
	) u_fclr (
		.clk(pclk),
		.rst_n(presetn),
		.level(fault_clear_input | r.fclr_sw),
		.done(fclr_done)
	);

	// Setting switch value 1 disables contactor drive
	assign contactor_en = (r.setting_sw != CAI_SW_NO_CONTACTOR);
	// Servo-on rising edge is the operation request; in multi-axis mode the
	// link input carries the coordinated axis only
	assign clear_req = link_in.servo_on & ~r.servo_on_d;
	assign any_alarm = r.conv_alarm | link_in.drive_alarm;

	always_comb begin
		status_word = '0;
		status_word[CAI_ST_CONV_ALARM] = r.conv_alarm;
		status_word[CAI_ST_CONTACTOR] = r.out.contactor_drive;
		status_word[CAI_ST_DRV_REPORT] = r.out.drive_alarm_report;
		status_word[CAI_ST_FAULT_FLAG] = r.out.fault_flag_output;
		status_word[CAI_ST_NOT_READY] = r.not_ready;
		status_word[CAI_ST_STATE_LSB +: 2] = r.state;
	end

	always_comb begin
		next_r = r;
		next_r.servo_on_d = link_in.servo_on;

		// Alarm latch: a trip wins over a clear in the same cycle
		if (link_in.conv_fault) begin
			next_r.conv_alarm = 1'b1;
		end else if (r.conv_alarm && clear_req) begin
			next_r.conv_alarm = 1'b0;
		end

		// Fault-clear after a qualified hold: not-ready when nothing to clear
		if (fclr_done && !any_alarm) begin
			next_r.not_ready = 1'b1;
		end else if (clear_req) begin
			next_r.not_ready = 1'b0;
		end

		unique case (r.state)
			CAI_IDLE: begin
				if (next_r.conv_alarm) begin
					next_r.state = CAI_TRIP;
				end else if (link_in.drive_start && !link_in.drive_alarm) begin
					next_r.state = CAI_RUN;
				end
			end
			CAI_RUN: begin
				if (next_r.conv_alarm) begin
					next_r.state = CAI_TRIP;
				end else if (!link_in.drive_start || link_in.drive_alarm) begin
					next_r.state = CAI_IDLE;
				end
			end
			CAI_TRIP: begin
				if (!next_r.conv_alarm) begin
					next_r.state = CAI_IDLE;
				end
			end
			default: begin
				next_r.state = CAI_IDLE;
			end
		endcase

		// Contactor closes only in RUN; with drive disabled it is left open
		next_r.out.contactor_drive = contactor_en && (next_r.state == CAI_RUN);
		// With contactor disabled the alarm is signalled but power stays with
		// the external sequence
		next_r.out.drive_alarm_report = next_r.conv_alarm && link_in.servo_on;
		next_r.out.alarm_contact_no = next_r.conv_alarm;
		next_r.out.alarm_contact_nc = ~next_r.conv_alarm;
		next_r.out.fault_flag_output = ~(next_r.conv_alarm | link_in.drive_alarm);
		next_r.out.not_ready = next_r.not_ready;

		// APB slave: zero wait states
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;
		if (psel && !penable) begin
			next_r.pready = 1'b1;
			next_r.prdata = '0;
			unique case (paddr)
				CAI_OFS_CTRL: begin
					next_r.prdata[CAI_CTRL_SW_LSB +: CAI_CTRL_SW_W] = r.setting_sw;
					next_r.prdata[CAI_CTRL_MULTI_BIT] = r.multi_axis;
				end
				CAI_OFS_STATUS: begin
					next_r.prdata = status_word;
				end
				CAI_OFS_CAUSE: begin
					next_r.prdata[3:0] = link_in;
				end
				default: begin
					next_r.pslverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && r.pready && pwrite && paddr == CAI_OFS_CTRL) begin
			next_r.setting_sw = pwdata[CAI_CTRL_SW_LSB +: CAI_CTRL_SW_W];
			next_r.multi_axis = pwdata[CAI_CTRL_MULTI_BIT];
			// Software fault-clear is a level that stands until written low
			next_r.fclr_sw = pwdata[CAI_CTRL_FCLR_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.setting_sw <= CAI_CTRL_SW_RST;
			r.state <= CAI_IDLE;
			r.out.alarm_contact_nc <= 1'b1;
			r.out.fault_flag_output <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign link_out = r.out;

endmodule : cai_interlock

// ==== verification/cai_interlock_properties.sv ====
// Checker of the interlock link outputs, bound to cai_interlock.
// Assumes link pins are sampled on pclk.
`timescale 1ns/1ps
module cai_interlock_properties
	import cai_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire cai_in_s link_in, // Link inputs
	input wire cai_out_s link_out // Link outputs
);
	wire al = link_out.alarm_contact_no;
	wire ct = link_out.contactor_drive;
	wire rp = link_out.drive_alarm_report;
	wire so = link_in.servo_on;
	wire cf = link_in.conv_fault;
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	contact_pair_a: assert property (link_out.alarm_contact_nc != al)
		else $error("contact pairs equal");
	fault_latch_a: assert property (cf |=> al)
		else $error("alarm not latched");
	trip_opens_a: assert property (cf |=> !ct)
		else $error("contactor closed in alarm");
	start_gate_a: assert property ($rose(ct) |-> $past(link_in.drive_start) && !$past(al))
		else $error("contactor closed unasked");
	servo_off_quiet_a: assert property (!so |=> !rp)
		else $error("report in servo off");
	flag_low_a: assert property (al |-> !link_out.fault_flag_output)
		else $error("flag high in alarm");
	latch_hold_a: assert property (al && !$rose(so) |=> al)
		else $error("alarm dropped");
	clear_cause_a: assert property ($fell(al) |-> $past(so) && !$past(cf))
		else $error("alarm cleared early");
	cover property (ct);
	cover property (rp);
	cover property ($fell(al));
	cover property (link_out.not_ready);
endmodule : cai_interlock_properties
bind cai_interlock cai_interlock_properties u_cai_interlock_properties (.pclk(pclk),
	.presetn(presetn), .link_in(link_in), .link_out(link_out));

// ==== verification/cai_drive_model.sv ====
// Drive unit model: takes its own alarm on a converter report.
// Assumes controller commands arrive as levels on clk.
`timescale 1ns/1ps
module cai_drive_model (
	input wire logic clk, // Clock
	input wire logic rst_n, // Control power, active low
	input wire logic start_cmd, // Start request
	input wire logic servo_cmd, // Servo-on request
	input wire logic err_reset, // Error reset
	input wire logic report, // Converter alarm report
	output logic drive_start, // Start to converter
	output logic servo_on, // Servo-on state
	output logic drive_alarm // Own alarm held
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_alarm <= 1'b0;
		end else if (report) begin
			drive_alarm <= 1'b1;
		end else if (err_reset) begin
			drive_alarm <= 1'b0;
		end
	end
	assign drive_start = start_cmd;
	assign servo_on = servo_cmd && !drive_alarm;
endmodule : cai_drive_model

// ==== verification/cai_interlock_test.sv ====
// Bench of cai_interlock: APB reads are checked against a queue of notes.
// Assumes zero-wait APB and the drive unit model on the link.
`timescale 1ns/1ps
module cai_interlock_test;
	import cai_pkg::*;
	typedef struct packed {
		logic [32:0] v;
		logic [32:0] m;
	} cai_note_s;
	localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic st, sc, er, cf, fc, ds, so, da;
	int rp_cycles = 0;
	cai_in_s link_in;
	cai_out_s link_out;
	cai_note_s notes[$];
	cai_note_s n;
	int miscompares, cmp_count;
	int seed = 32'h03008C15;
	assign link_in = {ds, so, da, cf};
	cai_interlock #(.FCLR_CYCLES(8)) u_cai_interlock (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link_in(link_in),
		.fault_clear_input(fc), .link_out(link_out));
	cai_drive_model u_cai_drive_model (.clk(pclk), .rst_n(presetn), .start_cmd(st),
		.servo_cmd(sc), .err_reset(er), .report(link_out.drive_alarm_report),
		.drive_start(ds), .servo_on(so), .drive_alarm(da));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic check(input string w, input logic [32:0] s, input logic [32:0] e);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", w, e, s);
		end
	endtask : check
	function automatic logic [32:0] stv(input logic a, c, r, nr, input logic [1:0] s);
		return {26'h0, s, nr, ~a, r, c, a};
	endfunction : stv
	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask : cyc
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [32:0] v, input logic [32:0] m);
		notes.push_back({v, m});
		apb(a, 1'b0, 32'h0);
	endtask : rd
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	// Result watcher: each completed read takes the oldest note
	always @(posedge pclk) begin
		if (link_out.drive_alarm_report === 1'b1) rp_cycles <= rp_cycles + 1;
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
			n = notes.pop_front();
			check("apb read", {pslverr, prdata} & n.m, n.v & n.m);
		end
	end
	initial begin
		cyc(5000);
		miscompares++;
		report_and_stop();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		{st, sc, er, cf, fc} = '0;
		cyc(20);
		presetn <= 1'b1;
		cyc(1);
		rd(CAI_OFS_CTRL, 33'h0, ALL);
		rd(CAI_OFS_STATUS, stv(0, 0, 0, 0, CAI_IDLE), ALL);
		apb(8'h0C, 1'b1, $random(seed));
		rd(8'h0C, {1'b1, 32'h0}, ALL);
		st <= 1'b1;
		cyc(4);
		rd(CAI_OFS_STATUS, stv(0, 1, 0, 0, CAI_RUN), ALL);
		cf <= 1'b1;
		cyc(4);
		rd(CAI_OFS_STATUS, stv(1, 0, 0, 0, CAI_TRIP), ALL);
		check("link out", {27'h0, link_out}, 33'h10);
		sc <= 1'b1;
		cyc(6);
		rd(CAI_OFS_STATUS, stv(1, 0, 0, 0, CAI_TRIP), ALL ^ 33'h4);
		check("report cycles", 33'(rp_cycles), 33'd2);
		cf <= 1'b0;
		sc <= 1'b0;
		st <= 1'b0;
		er <= 1'b1;
		cyc(2);
		er <= 1'b0;
		sc <= 1'b1;
		cyc(4);
		er <= 1'b1;
		cyc(2);
		er <= 1'b0;
		rd(CAI_OFS_STATUS, stv(0, 0, 0, 0, CAI_IDLE), ALL ^ 33'h4);
		st <= 1'b1;
		cyc(4);
		rd(CAI_OFS_STATUS, stv(0, 1, 0, 0, CAI_RUN), ALL);
		apb(CAI_OFS_CTRL, 1'b1, ($random(seed) & 32'hFFFF_FFC0) | 32'h1);
		rd(CAI_OFS_CTRL, 33'h1, 33'h1_0000_003F);
		rd(CAI_OFS_STATUS, stv(0, 0, 0, 0, CAI_RUN), ALL);
		fc <= 1'b1;
		cyc(10);
		fc <= 1'b0;
		cyc(4);
		rd(CAI_OFS_STATUS, stv(0, 0, 0, 1, CAI_IDLE), 33'h1F);
		// A new servo-on request leaves not-ready, then software holds the clear
		sc <= 1'b0;
		cyc(2);
		sc <= 1'b1;
		cyc(2);
		rd(CAI_OFS_STATUS, stv(0, 0, 0, 0, CAI_RUN), ALL);
		apb(CAI_OFS_CTRL, 1'b1, ($random(seed) & 32'hFFFF_FFC0) | 32'h31);
		cyc(10);
		apb(CAI_OFS_CTRL, 1'b1, ($random(seed) & 32'hFFFF_FFC0) | 32'h11);
		cyc(2);
		rd(CAI_OFS_STATUS, stv(0, 0, 0, 1, CAI_RUN), ALL);
		rd(CAI_OFS_CTRL, 33'h11, ALL);
		check("link out", {27'h0, link_out}, 33'h23);
		// Contactor drive disabled: the external sequence drops power itself
		cf <= 1'b1;
		st <= 1'b0;
		cyc(4);
		rd(CAI_OFS_STATUS, stv(1, 0, 0, 1, CAI_TRIP), ALL);
		check("report cycles", 33'(rp_cycles), 33'd4);
		check("link out", {27'h0, link_out}, 33'h11);
		sc <= 1'b0;
		cf <= 1'b0;
		er <= 1'b1;
		cyc(2);
		er <= 1'b0;
		sc <= 1'b1;
		cyc(2);
		st <= 1'b1;
		cyc(4);
		rd(CAI_OFS_STATUS, stv(0, 0, 0, 0, CAI_RUN), ALL);
		// Control power cycle clears a latched alarm once the cause is gone
		sc <= 1'b0;
		cf <= 1'b1;
		cyc(2);
		cf <= 1'b0;
		presetn <= 1'b0;
		cyc(2);
		presetn <= 1'b1;
		cyc(1);
		rd(CAI_OFS_STATUS, stv(0, 1, 0, 0, CAI_RUN), ALL);
		check("link out", {27'h0, link_out}, 33'h2A);
		report_and_stop();
	end
endmodule : cai_interlock_test
